// ---- hw/spi_diag_cfg.svh ----
// Constants of the serial command decoder: command codes, reset values, sizes.
// Assumes inclusion by the decoder only.
`ifndef SPI_DIAG_CFG_SVH
`define SPI_DIAG_CFG_SVH

`define FRAME_BITS      5'h10
`define WDT_TRIG        16'h6A55
`define PRESC_HI        12'h60F
`define LINE_SW_HI      8'h9C
`define LINE_FIRST_OFF  16'h9CF0
`define LINE_FIRST_ON   16'h9CFF
`define LINE_SECOND_OFF 16'h9C00
`define LINE_SECOND_ON  16'h9C0F
`define SWITCH_CODES    16'h9A5A, 16'h930F, 16'h93F0, 16'h9396, 16'h960F, 16'h96F0, \
                        16'h99F0, 16'h99FF, 16'h9900, 16'h990F
`define IP_WRITE_HI     8'hA9
`define MON_OFF         16'hC000
`define MON_HI          8'hCA
`define MON_LO_CODES    8'h31, 8'h32, 8'h34, 8'h38, 8'h61, 8'h62, 8'h64, 8'h68, 8'h92, \
                        8'h94, 8'h98, 8'hC1, 8'hC2, 8'hC4, 8'hC8, 8'hE1, 8'hE2, 8'hE4
`define SRC_HI_TAG      5'h1E
`define SRC_CH_MIN      3'h1
`define SRC_CH_MAX      3'h5
`define SRC_10V_M10     8'h33
`define SRC_10V_M15     8'h3C
`define SRC_5V_M10      8'hC3
`define SRC_5V_M15      8'hCC
`define TEST_ECHO_A     16'h55AA
`define TEST_ECHO_B     16'hAA55
`define TEST_IP_READ    16'h5500
`define TEST_IP_HI      8'h01
`define TEST_ENTER      16'h5A5A
`define SUPPLIER_A      16'hE6B5
`define SUPPLIER_B      16'hE6BA
`define FLAG_POR_VALUE  1'h1

`endif

// ---- hw/spi_diag_pkg.sv ----
// Types shared by the serial command decoder.
// Assumes the constants header sits beside it.
`default_nettype none
package spi_diag_pkg;

    typedef enum logic [1:0] {
        ANS_STATUS,
        ANS_ECHO_A,
        ANS_ECHO_B,
        ANS_IP_READ
    } ans_sel_e;

    // Supervision levels feeding the status word, all asynchronous to mclk
    typedef struct packed {
        logic [2:0] overtemp;       // [2] chip, [1] first line port, [0] second
        logic       key_latch;
        logic       boost_high;     // 33 V or external divider
        logic       pump_sw_low_z;
        logic       pump_out_low;
        logic       charge_pump_low;
        logic       comparator_high;
        logic       ground_open;
        logic [2:0] wdt_prescale;
    } status_in_s;

    // Test-mode strap levels and related pin levels
    typedef struct packed {
        logic reset_output_first;
        logic line_transmit_first;
        logic reset_output_second;
        logic line_transmit_second;
        logic lock_bit;
        logic [1:0] line_ls_mode;   // [1] first line port, [0] second, low-side mode
    } strap_in_s;

    typedef struct packed {
        logic       enable;
        logic [2:0] channel;
        logic       level_10v;
        logic       mirror_15;
    } meas_src_s;

endpackage
`default_nettype wire

// ---- hw/spi_diag_status_testmode.sv ----
// Serial command decoder with status word, diagnosis selections and test mode.
// Assumes a 16-bit serial master: clock idles low, device shifts on the rising
// edge and samples on the falling edge, chip select low for the frame.
// Function
// - Monitor selection drops on any valid command except watchdog trigger, 9Cxx.
// - Source command high byte 11110 plus channel; only channels 1 to 5 valid.
// - Low byte 33h: 10 V, 10:1 mirror; 3Ch: 10 V, 15:1 mirror.
// - Low byte C3h: 5 V, 10:1 mirror; CCh: 5 V, 15:1 mirror.
// - Source setting drops on any later valid command except watchdog trigger, 9Cxx.
// - Every command except the three test codes returns the status word.
// - a7 chip, a6 first port, a5 second port overtemperature.
// - a4 key latch set; a3 boost rail at 33 V or external divider.
// - a2 pump switch low impedance; a1 pump output low; a0 charge pump low.
// - b7 comparator above threshold; b6 a ground pin disconnected.
// - b5 previous command invalid; high after power-on.
// - b4 error in last transmission; high after power-on.
// - b3 high in test mode.
// - b2..b0 mirror the watchdog prescaler setting.
// - Overtemperature bits latch; clear on next command unless still hot.
// - Other resets keep b5 and b4.
// - 55AAh answered by AA55h; AA55h answered by 55AAh.
// - 5500h answered by 01h and the programming register byte.
// - 5A5Ah enters test mode only with the pin straps in place.
// - Test mode stays latched and disables the watchdog.
// - Test mode with lock clear raises the buck rail to programming level.
// - Any reset leaves test mode.
// - Line-port switching commands invalid while ports are in protocol mode.
// - Programming register write accepted only in test mode.
`default_nettype none
`include "spi_diag_cfg.svh"

module spi_diag_status_testmode (
    input  wire logic                    mclk,            // System clock, 50 MHz
    input  wire logic                    rst_b,           // Any reset, async, low
    input  wire logic                    por_b,           // Power-on reset, async, low
    input  wire logic                    spi_sclk,        // Serial clock from master
    input  wire logic                    spi_cs_b,        // Frame select, low active
    input  wire logic                    spi_mosi,        // Command bits, MSB first
    output var  logic                    spi_miso,        // Answer bits, MSB first
    input  wire spi_diag_pkg::status_in_s status_in,      // Supervision levels
    input  wire spi_diag_pkg::strap_in_s  strap_in,       // Strap and mode levels
    input  wire logic [7:0]              ip_contents,     // Programming register
    output var  logic                    analog_selector_en, // Monitor output active
    output var  logic [7:0]              analog_selector, // Selected monitor code
    output var  spi_diag_pkg::meas_src_s resistance_meas_source, // Source setting
    output var  logic                    ip_write,        // Register write pulse
    output var  logic [7:0]              ip_data,         // Register write byte
    output var  logic                    test_mode,       // Test mode latched
    output var  logic                    wdt_disable,     // Watchdog held off
    output var  logic                    buck_prog_level  // Buck rail to program level
);
    import spi_diag_pkg::*;

    // ------------------------------------------------------------
    // Link side: receive and transmit shifters on the serial clock
    // ------------------------------------------------------------
    // Frame-start flags are preset while select is high; the counters are
    // not, so their last values survive for the system side after the frame.
    logic        rx_first_q;
    logic        tx_first_q;
    logic [4:0]  rx_cnt_q;
    logic [15:0] rx_q;
    logic [3:0]  tx_idx_q;
    logic [15:0] ans_q;
    logic [4:0]  rx_cnt_inc;

    assign rx_cnt_inc = (rx_cnt_q == 5'h1F) ? rx_cnt_q : rx_cnt_q + 5'h01;

    always_ff @(negedge spi_sclk or posedge spi_cs_b) begin
        if (spi_cs_b) begin
            rx_first_q <= 1'b1;
        end else begin
            rx_first_q <= 1'b0;
        end
    end

    always_ff @(negedge spi_sclk or negedge rst_b) begin
        if (!rst_b) begin
            rx_cnt_q <= 5'h00;
            rx_q     <= 16'h0000;
        end else begin
            rx_cnt_q <= rx_first_q ? 5'h01 : rx_cnt_inc;
            rx_q     <= {rx_q[14:0], spi_mosi};
        end
    end

    always_ff @(posedge spi_sclk or posedge spi_cs_b) begin
        if (spi_cs_b) begin
            tx_first_q <= 1'b1;
        end else begin
            tx_first_q <= 1'b0;
        end
    end

    // Answer word is frozen in the system domain for the whole frame
    always_ff @(posedge spi_sclk or negedge rst_b) begin
        if (!rst_b) begin
            tx_idx_q <= 4'h0;
            spi_miso <= 1'b0;
        end else if (tx_first_q) begin
            tx_idx_q <= 4'hE;
            spi_miso <= ans_q[15];
        end else begin
            tx_idx_q <= tx_idx_q - 4'h1;
            spi_miso <= ans_q[tx_idx_q];
        end
    end

    // ------------------------------------------------------------
    // System side: synchronisers
    // ------------------------------------------------------------
    logic       cs_m1_q, cs_m2_q, cs_m3_q;
    status_in_s st_m1_q, st_s_q;
    strap_in_s  sp_m1_q, sp_s_q;
    logic       frame_end, frame_start;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cs_m1_q <= 1'b1;
            cs_m2_q <= 1'b1;
            cs_m3_q <= 1'b1;
            st_m1_q <= '0;
            st_s_q  <= '0;
            sp_m1_q <= '0;
            sp_s_q  <= '0;
        end else begin
            cs_m1_q <= spi_cs_b;
            cs_m2_q <= cs_m1_q;
            cs_m3_q <= cs_m2_q;
            st_m1_q <= status_in;
            st_s_q  <= st_m1_q;
            sp_m1_q <= strap_in;
            sp_s_q  <= sp_m1_q;
        end
    end

    assign frame_end   = cs_m2_q & ~cs_m3_q;
    assign frame_start = ~cs_m2_q & cs_m3_q;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // Shift data is quiet once select has risen, so it is read directly here.
    logic [15:0] cmd;
    logic        len_ok, is_wdt, is_presc, is_switch, is_port_sw, is_port_ok, is_ip;
    logic        is_mon, is_src, is_test, cmd_valid, keeps_diag, go_test;
    logic        src_ch_ok, src_lo_ok, take;

    assign cmd        = rx_q;
    assign len_ok     = (rx_cnt_q == `FRAME_BITS);
    assign is_wdt     = (cmd == `WDT_TRIG);
    assign is_presc   = (cmd[15:4] == `PRESC_HI) && !cmd[3];
    assign is_switch  = cmd inside {`SWITCH_CODES};
    assign is_port_sw = (cmd[15:8] == `LINE_SW_HI);
    assign is_port_ok = ((cmd == `LINE_FIRST_OFF || cmd == `LINE_FIRST_ON)
                           && sp_s_q.line_ls_mode[1])
                        || ((cmd == `LINE_SECOND_OFF || cmd == `LINE_SECOND_ON)
                           && sp_s_q.line_ls_mode[0]);
    assign is_ip      = (cmd[15:8] == `IP_WRITE_HI) && test_mode;
    assign is_mon     = (cmd == `MON_OFF)
                        || ((cmd[15:8] == `MON_HI) && (cmd[7:0] inside {`MON_LO_CODES}));
    assign src_ch_ok  = (cmd[10:8] >= `SRC_CH_MIN) && (cmd[10:8] <= `SRC_CH_MAX);
    assign src_lo_ok  = cmd[7:0] inside {`SRC_10V_M10, `SRC_10V_M15,
                                         `SRC_5V_M10, `SRC_5V_M15};
    assign is_src     = (cmd[15:11] == `SRC_HI_TAG) && src_ch_ok && src_lo_ok;
    assign is_test    = cmd inside {`TEST_ECHO_A, `TEST_ECHO_B, `TEST_IP_READ,
                                    `TEST_ENTER, `SUPPLIER_A, `SUPPLIER_B};
    assign cmd_valid  = is_wdt | is_presc | is_switch | is_port_ok | is_ip
                        | is_mon | is_src | is_test;
    assign keeps_diag = is_wdt | is_port_sw;
    assign take       = frame_end & len_ok & cmd_valid;
    assign go_test    = take && (cmd == `TEST_ENTER)
                        && !sp_s_q.reset_output_first && !sp_s_q.line_transmit_first
                        && sp_s_q.reset_output_second && sp_s_q.line_transmit_second;

    // ------------------------------------------------------------
    // Flags kept across ordinary resets
    // ------------------------------------------------------------
    logic invalid_q, xfer_err_q;

    always_ff @(posedge mclk or negedge por_b) begin
        if (!por_b) begin
            invalid_q  <= `FLAG_POR_VALUE;
            xfer_err_q <= `FLAG_POR_VALUE;
        end else if (frame_end) begin
            xfer_err_q <= !len_ok;
            if (len_ok) begin
                invalid_q <= !cmd_valid;
            end
        end
    end

    // ------------------------------------------------------------
    // Diagnosis selections, test mode, overtemperature latches
    // ------------------------------------------------------------
    logic [2:0] ot_q, ot_d;
    ans_sel_e   ans_sel_q, ans_sel_d;
    logic [15:0] status_word, ans_d;

    // Set wins over the clear at frame end; still-hot bits stay high
    assign ot_d = frame_end ? st_s_q.overtemp : (ot_q | st_s_q.overtemp);

    assign ans_sel_d = !take                  ? ANS_STATUS  :
                       (cmd == `TEST_ECHO_A)  ? ANS_ECHO_A  :
                       (cmd == `TEST_ECHO_B)  ? ANS_ECHO_B  :
                       (cmd == `TEST_IP_READ) ? ANS_IP_READ : ANS_STATUS;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            analog_selector_en     <= 1'b0;
            analog_selector        <= 8'h00;
            resistance_meas_source <= '0;
            ip_write               <= 1'b0;
            ip_data                <= 8'h00;
            test_mode              <= 1'b0;
            wdt_disable            <= 1'b0;
            buck_prog_level        <= 1'b0;
            ot_q                   <= 3'h0;
            ans_sel_q              <= ANS_STATUS;
            ans_q                  <= 16'h0000;
        end else begin
            ot_q            <= ot_d;
            ip_write        <= take & is_ip;
            test_mode       <= test_mode | go_test;
            wdt_disable     <= test_mode;
            buck_prog_level <= test_mode & !sp_s_q.lock_bit;
            if (frame_end) begin
                ans_sel_q <= ans_sel_d;
            end
            if (frame_start) begin
                ans_q <= ans_d;
            end
            if (take && is_ip) begin
                ip_data <= cmd[7:0];
            end
            if (take && !keeps_diag) begin
                analog_selector_en     <= is_mon && (cmd != `MON_OFF);
                analog_selector        <= is_mon ? cmd[7:0] : 8'h00;
                resistance_meas_source <= '0;
                if (is_src) begin
                    resistance_meas_source.enable    <= 1'b1;
                    resistance_meas_source.channel   <= cmd[10:8];
                    resistance_meas_source.level_10v <= !cmd[7];
                    resistance_meas_source.mirror_15 <= cmd[2];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Answer word, frozen at frame start
    // ------------------------------------------------------------
    assign status_word = {ot_d,
                          st_s_q.key_latch, st_s_q.boost_high,
                          st_s_q.pump_sw_low_z, st_s_q.pump_out_low,
                          st_s_q.charge_pump_low,
                          st_s_q.comparator_high, st_s_q.ground_open,
                          invalid_q, xfer_err_q,
                          test_mode,
                          st_s_q.wdt_prescale};

    assign ans_d = (ans_sel_q == ANS_ECHO_A)  ? `TEST_ECHO_B :
                   (ans_sel_q == ANS_ECHO_B)  ? `TEST_ECHO_A :
                   (ans_sel_q == ANS_IP_READ) ? {`TEST_IP_HI, ip_contents} :
                   status_word;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b || !por_b);

    property p_len_err;
        frame_end && !len_ok |=> xfer_err_q && $stable(invalid_q);
    endproperty
    a_len_err: assert property (p_len_err) else $error("short frame not flagged");

    property p_invalid;
        frame_end && len_ok |=> invalid_q == !$past(cmd_valid);
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid flag wrong");

    property p_mon_keep;
        take && keeps_diag && analog_selector_en |=> analog_selector_en;
    endproperty
    a_mon_keep: assert property (p_mon_keep) else $error("monitor dropped");

    property p_src_cancel;
        take && !keeps_diag && !is_src |=> !resistance_meas_source.enable;
    endproperty
    a_src_cancel: assert property (p_src_cancel) else $error("source kept");

    property p_src_chan;
        resistance_meas_source.enable |-> resistance_meas_source.channel inside {[1:5]};
    endproperty
    a_src_chan: assert property (p_src_chan) else $error("bad source channel");

    property p_test_entry;
        $rose(test_mode) |-> $past(go_test);
    endproperty
    a_test_entry: assert property (p_test_entry) else $error("test mode without entry");

    property p_test_sticky;
        test_mode |=> test_mode ##1 wdt_disable;
    endproperty
    a_test_sticky: assert property (p_test_sticky) else $error("test mode lost");

    property p_buck;
        test_mode && !sp_s_q.lock_bit ##1 !sp_s_q.lock_bit |-> buck_prog_level;
    endproperty
    a_buck: assert property (p_buck) else $error("buck level not raised");

    property p_echo;
        frame_start && ans_sel_q == ANS_ECHO_A |=> ans_q == 16'hAA55;
    endproperty
    a_echo: assert property (p_echo) else $error("echo answer wrong");

    property p_ot_clear;
        frame_end && st_s_q.overtemp == 3'h0 |=> ot_q == 3'h0;
    endproperty
    a_ot_clear: assert property (p_ot_clear) else $error("overtemp not cleared");

    property p_port_default;
        frame_end && len_ok && is_port_sw && sp_s_q.line_ls_mode == 2'h0 |=> invalid_q;
    endproperty
    a_port_default: assert property (p_port_default) else $error("switch code accepted");

    property p_ip_guard;
        ip_write |-> $past(test_mode);
    endproperty
    a_ip_guard: assert property (p_ip_guard) else $error("write outside test");

    property p_ot_set;
        |st_s_q.overtemp |=> (ot_q & $past(st_s_q.overtemp)) == $past(st_s_q.overtemp);
    endproperty
    a_ot_set: assert property (p_ot_set) else $error("overtemp not latched");

    property p_echo_b;
        frame_start && ans_sel_q == ANS_ECHO_B |=> ans_q == 16'h55AA;
    endproperty
    a_echo_b: assert property (p_echo_b) else $error("second echo wrong");

    property p_ip_read;
        frame_start && ans_sel_q == ANS_IP_READ |=> ans_q == {8'h01, $past(ip_contents)};
    endproperty
    a_ip_read: assert property (p_ip_read) else $error("register read answer wrong");

endmodule
`default_nettype wire

// ---- verif/spi_diag_status_testmode_bench.sv ----
// Self-checking bench of the serial command decoder.
// Assumes the host model and the design package are compiled first.
`default_nettype none

module spi_diag_status_testmode_bench;
    import spi_diag_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic                  mclk = 1'b0;
    logic                  rst_b = 1'b0;
    logic                  por_b = 1'b0;
    wire                   sclk, cs_b, mosi;
    logic                  miso, mon_en, ip_write, test_mode, wdt_disable, buck_prog;
    logic [7:0]            asel, ip_data;
    meas_src_s             msrc;
    status_in_s            st = '0;
    strap_in_s             sp = 7'b1100000;
    logic [7:0]            ipc = 8'hA5;
    logic                  ipw_seen = 1'b0;
    int                    bad_count = 0;
    int                    checks = 0;
    int                    cyc = 0;

    always #10 mclk = ~mclk;

    spi_host_model u_spi_host_model (.spi_sclk(sclk), .spi_cs_b(cs_b), .spi_mosi(mosi),
        .spi_miso(miso));

    spi_diag_status_testmode u_spi_diag_status_testmode (.mclk(mclk), .rst_b(rst_b),
        .por_b(por_b), .spi_sclk(sclk), .spi_cs_b(cs_b), .spi_mosi(mosi), .spi_miso(miso),
        .status_in(st), .strap_in(sp), .ip_contents(ipc), .analog_selector_en(mon_en),
        .analog_selector(asel), .resistance_meas_source(msrc), .ip_write(ip_write),
        .ip_data(ip_data), .test_mode(test_mode), .wdt_disable(wdt_disable),
        .buck_prog_level(buck_prog));

    // The write strobe is one cycle wide, so it is caught here
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (ip_write === 1'b1) ipw_seen <= 1'b1;
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic close_out();
        $display("bad_count=%0d checks=%0d", bad_count, checks);
        if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [15:0] sw(logic b5, logic b4, logic b3, logic [2:0] ot);
        return {ot, st.key_latch, st.boost_high, st.pump_sw_low_z, st.pump_out_low,
                st.charge_pump_low, st.comparator_high, st.ground_open, b5, b4, b3,
                st.wdt_prescale};
    endfunction

    // Sends a command and judges the answer to the one before it
    task automatic ask(input logic [15:0] c, input logic [15:0] e);
        logic [15:0] a;
        u_spi_host_model.xfer(c, 16, a);
        chk(a, e);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_status();
        logic [15:0] a;
        ask(16'h6A55, sw(1, 1, 0, 3'h0));
        @(posedge mclk) st <= 13'h1555;
        repeat (4) @(posedge mclk);
        ask(16'h6A55, sw(0, 0, 0, 3'h5));
        @(posedge mclk) st <= 13'h0AAA;
        repeat (4) @(posedge mclk);
        ask(16'h6A55, sw(0, 0, 0, 3'h7));
        ask(16'h1234, sw(0, 0, 0, 3'h2));
        ask(16'h6A55, sw(1, 0, 0, 3'h2));
        u_spi_host_model.xfer(16'h6A55, 8, a);
        ask(16'h6A55, sw(0, 1, 0, 3'h2));
    endtask

    task automatic t_select();
        logic [15:0] codes [4] = '{16'hF133, 16'hF23C, 16'hF3C3, 16'hF5CC};
        logic [5:0]  exp   [4] = '{6'b1_001_10, 6'b1_010_11, 6'b1_011_00, 6'b1_101_01};
        ask(16'hCA31, sw(0, 0, 0, 3'h2));
        chk(16'({mon_en, asel}), 16'h0131);
        ask(16'h6A55, sw(0, 0, 0, 3'h2));
        ask(16'h9CF0, sw(0, 0, 0, 3'h2));
        chk(16'(mon_en), 16'h0001);
        ask(16'h60F3, sw(1, 0, 0, 3'h2));
        chk(16'(mon_en), 16'h0000);
        for (int i = 0; i < 4; i++) begin
            ask(codes[i], sw(0, 0, 0, 3'h2));
            chk(16'(msrc), 16'(exp[i]));
        end
        ask(16'h6A55, sw(0, 0, 0, 3'h2));
        ask(16'hF033, sw(0, 0, 0, 3'h2));
        ask(16'hF633, sw(1, 0, 0, 3'h2));
        chk(16'(msrc), 16'h0035);
        ask(16'hE6B5, sw(1, 0, 0, 3'h2));
        chk(16'(msrc.enable), 16'h0000);
        ask(16'hCA31, sw(0, 0, 0, 3'h2));
        ask(16'hC000, sw(0, 0, 0, 3'h2));
        chk(16'({mon_en, asel}), 16'h0000);
    endtask

    task automatic t_echo();
        ask(16'h55AA, sw(0, 0, 0, 3'h2));
        ask(16'hAA55, 16'hAA55);
        ask(16'h5500, 16'h55AA);
        ask(16'hA912, {8'h01, ipc});
        ask(16'h6A55, sw(1, 0, 0, 3'h2));
        chk(16'(ipw_seen), 16'h0000);
    endtask

    task automatic t_test();
        ask(16'h5A5A, sw(0, 0, 0, 3'h2));
        chk(16'(test_mode), 16'h0000);
        @(posedge mclk) sp <= 7'b0011010;
        repeat (4) @(posedge mclk);
        ask(16'h5A5A, sw(0, 0, 0, 3'h2));
        chk(16'({test_mode, wdt_disable, buck_prog}), 16'h0007);
        ask(16'hA95C, sw(0, 0, 1, 3'h2));
        chk(16'({ipw_seen, ip_data}), 16'h015C);
        ask(16'h9CF0, sw(0, 0, 1, 3'h2));
        @(posedge mclk) sp <= 7'b1100000;
        ask(16'h1234, sw(0, 0, 1, 3'h2));
        chk(16'(test_mode), 16'h0001);
        // Lock set while in test mode must drop the programming level
        @(posedge mclk) sp <= 7'b1100100;
        repeat (4) @(posedge mclk);
        chk(16'(buck_prog), 16'h0000);
    endtask

    task automatic t_reset();
        @(posedge mclk) rst_b <= 1'b0;
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(16'(test_mode), 16'h0000);
        ask(16'h6A55, sw(1, 0, 0, 3'h2));
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        por_b <= 1'b1;
        repeat (3) @(posedge mclk);
        t_status();
        t_select();
        t_echo();
        t_test();
        t_reset();
        close_out();
    end
endmodule
`default_nettype wire

// ---- verif/spi_host_model.sv ----
// Serial master standing in for the host controller.
// Assumes the bench calls xfer between frames only; sclk idles low.
`default_nettype none

module spi_host_model (
    output var logic spi_sclk, // Serial clock, stands still outside frames
    output var logic spi_cs_b, // Frame select, low active
    output var logic spi_mosi, // Command bits, MSB first
    input  wire logic spi_miso  // Answer bits from the device
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        spi_sclk = 1'b0;
        spi_cs_b = 1'b1;
        spi_mosi = 1'b0;
    end

    // ----------------------------------------------------------------
    // One frame: 80 ns bit time, odd offset keeps phase off mclk
    // ----------------------------------------------------------------
    task automatic xfer(input logic [15:0] cmd, input int nbits, output logic [15:0] ans);
        int k;
        ans = 16'h0000;
        #13 spi_cs_b = 1'b0;
        #100;
        for (k = 0; k < nbits; k++) begin
            spi_mosi = cmd[15-k];
            spi_sclk = 1'b1;
            #40;
            ans = {ans[14:0], spi_miso};
            spi_sclk = 1'b0;
            #40;
        end
        // Released line shows the inverse, never a stale bit
        spi_mosi = ~spi_mosi;
        spi_cs_b = 1'b1;
        #200;
    endtask
endmodule
`default_nettype wire
